// >>> core/osh_pkg.sv
package osh_pkg;

  // register shape
  localparam int REG_W    = 16;
  localparam int FLAG_BIT = 1;
  localparam int NSUB     = 6;

  // sub-register order inside the summary vectors
  localparam int SUB_CAL  = 0;
  localparam int SUB_MEAS = 1;
  localparam int SUB_TRIG = 2;
  localparam int SUB_INIT = 3;
  localparam int SUB_LOW  = 4;
  localparam int SUB_HIGH = 5;

  // summary bit positions in the top-level operation register
  localparam int SUM_CAL  = 0;
  localparam int SUM_MEAS = 4;
  localparam int SUM_TRIG = 5;
  localparam int SUM_INIT = 10;
  localparam int SUM_LOW  = 11;
  localparam int SUM_HIGH = 12;
  localparam int SUM_POS [0:NSUB-1] = '{SUM_CAL, SUM_MEAS, SUM_TRIG, SUM_INIT, SUM_LOW, SUM_HIGH};

  // sub-registers whose event bit latches on start and on completion
  localparam logic [NSUB-1:0] EDGE_MASK = 6'h0B;

  // reset values
  localparam logic [REG_W-1:0] DATA_RST = 16'h0000;

  // initialization sequence length
  localparam int CLK_PERIOD_NS = 40;
  localparam int INIT_TIME_NS  = 400;
  localparam int INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // query selector: even codes condition, odd codes event
  typedef enum logic [3:0] {
    SEL_OP_COND   = 4'h0,
    SEL_OP_EVT    = 4'h1,
    SEL_CAL_COND  = 4'h2,
    SEL_CAL_EVT   = 4'h3,
    SEL_MEAS_COND = 4'h4,
    SEL_MEAS_EVT  = 4'h5,
    SEL_TRIG_COND = 4'h6,
    SEL_TRIG_EVT  = 4'h7,
    SEL_INIT_COND = 4'h8,
    SEL_INIT_EVT  = 4'h9,
    SEL_LOW_COND  = 4'hA,
    SEL_LOW_EVT   = 4'hB,
    SEL_HIGH_COND = 4'hC,
    SEL_HIGH_EVT  = 4'hD
  } osh_sel_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h1,
    SEQ_WAIT = 3'h2,
    SEQ_MEAS = 3'h4
  } osh_seq_t;

  typedef struct packed {
    logic     valid;
    osh_sel_t sel;
  } osh_query_t;

  typedef struct packed {
    logic             ack;
    logic [REG_W-1:0] data;
  } osh_answer_t;

  typedef struct packed {
    logic arm;
    logic trig;
    logic done;
    logic abort;
  } osh_seq_cmd_t;

endpackage

// >>> core/osh_evt_bit.sv
`timescale 1ns/1ns
module osh_evt_bit #(
  parameter bit BOTH_EDGES = 1'b1
) (
  input  wire logic clk,   // instrument clock
  input  wire logic nrst,  // async reset, low
  input  wire logic cond,  // condition level
  input  wire logic clr,   // read of the event register
  output logic      evt    // latched event bit
);

  typedef struct packed {
    logic cond_d;
    logic evt;
  } osh_evt_st_t;

  osh_evt_st_t st_ff;
  osh_evt_st_t nxt_st;
  logic        hit;

  // edge or level capture; set wins over a read in the same cycle
  always_comb
  begin
    hit           = BOTH_EDGES ? (cond ^ st_ff.cond_d) : cond;
    nxt_st.cond_d = cond;
    nxt_st.evt    = hit | (st_ff.evt & ~clr);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign evt = st_ff.evt;

endmodule // osh_evt_bit

// >>> core/osh_seq.sv
`timescale 1ns/1ns
module osh_seq (
  input  wire logic                  clk,     // instrument clock
  input  wire logic                  nrst,    // async reset, low
  input  wire osh_pkg::osh_seq_cmd_t cmd,     // arm, trigger, done, abort
  input  wire logic                  hold,    // initialization in progress
  output logic                       wait_o,  // armed, waiting for trigger
  output logic                       meas_o   // measurement running
);

  typedef struct packed {
    osh_pkg::osh_seq_t st;
  } osh_seq_st_t;

  osh_seq_st_t st_ff;
  osh_seq_st_t nxt_st;

  // arm, trigger, measure
  // idle -> wait -> measure -> idle; init or abort always win
  always_comb
  begin
    nxt_st = st_ff;
    if (hold || cmd.abort)
      nxt_st.st = osh_pkg::SEQ_IDLE;
    else
      case (st_ff.st)
        osh_pkg::SEQ_IDLE:
          if (cmd.arm)
            nxt_st.st = osh_pkg::SEQ_WAIT;
        osh_pkg::SEQ_WAIT:
          if (cmd.trig)
            nxt_st.st = osh_pkg::SEQ_MEAS;
        osh_pkg::SEQ_MEAS:
          if (cmd.done)
            nxt_st.st = osh_pkg::SEQ_IDLE;
        default:
          nxt_st.st = osh_pkg::SEQ_IDLE;
      endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_ff.st <= osh_pkg::SEQ_IDLE;
    else
      st_ff <= nxt_st;
  end

  assign wait_o = (st_ff.st == osh_pkg::SEQ_WAIT);
  assign meas_o = (st_ff.st == osh_pkg::SEQ_MEAS);

endmodule // osh_seq

// >>> core/osh_core.sv
`timescale 1ns/1ns
module osh_core #(
  parameter int VAL_W       = 24,                   // measured value width
  parameter int INIT_CYCLES = osh_pkg::INIT_CYCLES  // init sequence length
) (
  input  wire logic                  clk,          // instrument clock, 25 MHz
  input  wire logic                  nrst,         // async reset, low
  input  wire osh_pkg::osh_query_t   qry,          // host status query
  output osh_pkg::osh_answer_t       ans,          // query answer
  input  wire logic                  connect_evt,  // host link came up
  input  wire logic                  cmd_reset,    // common reset command
  input  wire logic                  cmd_preset,   // system preset command
  input  wire logic                  cal_start,    // calibration begins
  input  wire logic                  cal_done,     // calibration finished
  input  wire osh_pkg::osh_seq_cmd_t seq_cmd,      // arm, trigger, done, abort
  input  wire logic                  smp_valid,    // new measured value
  input  wire logic signed [VAL_W-1:0] smp_value,  // measured value
  input  wire logic signed [VAL_W-1:0] low_limit,  // lower limit
  input  wire logic signed [VAL_W-1:0] high_limit, // upper limit
  output logic                       init_busy     // initialization running
);

  localparam int CNT_W = $clog2(INIT_CYCLES + 1);

  // elaboration check on parameters
  // the init checks need at least two busy cycles and an end within their window
  if (VAL_W < 2 || INIT_CYCLES < 2 || INIT_CYCLES > 1000)
    $error("osh_core: VAL_W must be >= 2 and INIT_CYCLES within 2 to 1000");

  typedef struct packed {
    logic                      init_on;
    logic [CNT_W-1:0]          init_cnt;
    logic                      cal_on;
    logic                      low_on;
    logic                      high_on;
    logic                      ack;
    logic [osh_pkg::REG_W-1:0] data;
  } osh_core_st_t;

  osh_core_st_t               st_ff;
  osh_core_st_t               nxt_st;
  logic                       init_start;
  logic                       seq_wait;
  logic                       seq_meas;
  logic [osh_pkg::NSUB-1:0]   cond_vec;
  logic [osh_pkg::NSUB-1:0]   evt_vec;
  logic [osh_pkg::NSUB-1:0]   clr_vec;

  // sub-register word: only the flag bit is ever used
  function automatic logic [osh_pkg::REG_W-1:0] sub_word(input logic b);
    logic [osh_pkg::REG_W-1:0] w;
    w                    = osh_pkg::DATA_RST;
    w[osh_pkg::FLAG_BIT] = b;
    return w;
  endfunction

  // top-level word: place the six summaries at their positions
  function automatic logic [osh_pkg::REG_W-1:0] op_word(input logic [osh_pkg::NSUB-1:0] v);
    logic [osh_pkg::REG_W-1:0] w;
    w = osh_pkg::DATA_RST;
    for (int i = 0; i < osh_pkg::NSUB; i++)
      w[osh_pkg::SUM_POS[i]] = v[i];
    return w;
  endfunction

  // which sub-register a selector names; top-level codes give none
  function automatic logic [osh_pkg::NSUB-1:0] sel_hot(input osh_pkg::osh_sel_t s);
    logic [osh_pkg::NSUB-1:0] h;
    h = '0;
    for (int i = 0; i < osh_pkg::NSUB; i++)
      if (s[3:1] == 3'(i + 1))
        h[i] = 1'b1;
    return h;
  endfunction

  // trigger-wait and measuring state machine
  osh_seq u_seq (
    .clk    (clk),
    .nrst   (nrst),
    .cmd    (seq_cmd),
    .hold   (st_ff.init_on),
    .wait_o (seq_wait),
    .meas_o (seq_meas)
  );

  // init causes
  // power-up is covered by the reset value of init_on
  assign init_start = connect_evt | cmd_reset | cmd_preset;

  always_comb
  begin
    cond_vec                   = '0;
    cond_vec[osh_pkg::SUB_CAL]  = st_ff.cal_on;
    cond_vec[osh_pkg::SUB_MEAS] = seq_meas;
    cond_vec[osh_pkg::SUB_TRIG] = seq_wait;
    cond_vec[osh_pkg::SUB_INIT] = st_ff.init_on;
    cond_vec[osh_pkg::SUB_LOW]  = st_ff.low_on;
    cond_vec[osh_pkg::SUB_HIGH] = st_ff.high_on;
  end

  // event read clears
  // only odd selector codes address an event part
  assign clr_vec = (qry.valid && qry.sel[0]) ? sel_hot(qry.sel) : '0;

  // event latches
  // start/end capture for cal, meas, init; level capture for the rest
  for (genvar g = 0; g < osh_pkg::NSUB; g++)
  begin : g_evt
    osh_evt_bit #(
      .BOTH_EDGES (osh_pkg::EDGE_MASK[g])
    ) u_evt (
      .clk  (clk),
      .nrst (nrst),
      .cond (cond_vec[g]),
      .clr  (clr_vec[g]),
      .evt  (evt_vec[g])
    );
  end

  // next state of init, calibration, limits and answer
  always_comb
  begin
    nxt_st = st_ff;
    // init duration
    // a new cause restarts the count without dropping the level
    if (init_start)
    begin
      nxt_st.init_on  = 1'b1;
      nxt_st.init_cnt = '0;
    end
    else if (st_ff.init_on)
    begin
      if (st_ff.init_cnt == CNT_W'(INIT_CYCLES - 1))
        nxt_st.init_on = 1'b0;
      else
        nxt_st.init_cnt = st_ff.init_cnt + CNT_W'(1);
    end

    // calibration level
    // initialization cancels a running calibration
    if (init_start || st_ff.init_on)
      nxt_st.cal_on = 1'b0;
    else if (st_ff.cal_on && cal_done)
      nxt_st.cal_on = 1'b0;
    else if (!st_ff.cal_on && cal_start)
      nxt_st.cal_on = 1'b1;

    // limit compare
    // held from one sample to the next; cleared by initialization
    if (init_start || st_ff.init_on)
    begin
      nxt_st.low_on  = 1'b0;
      nxt_st.high_on = 1'b0;
    end
    else if (smp_valid)
    begin
      nxt_st.low_on  = (smp_value < low_limit);
      nxt_st.high_on = (smp_value > high_limit);
    end

    nxt_st.ack = qry.valid;
    if (qry.valid)
    begin
      case (qry.sel)
        osh_pkg::SEL_OP_COND:
          nxt_st.data = op_word(cond_vec);
        osh_pkg::SEL_OP_EVT:
          nxt_st.data = op_word(evt_vec);
        default:
          if (qry.sel[0])
            nxt_st.data = sub_word(|(evt_vec & sel_hot(qry.sel)));
          else
            nxt_st.data = sub_word(|(cond_vec & sel_hot(qry.sel)));
      endcase
    end
  end

  // init_on resets high so power-up runs an initialization
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff          <= '0;
      st_ff.init_on  <= 1'b1;
      st_ff.data     <= osh_pkg::DATA_RST;
    end
    else
      st_ff <= nxt_st;
  end

  assign ans       = '{ack: st_ff.ack, data: st_ff.data};
  assign init_busy = st_ff.init_on;

  // checks on the status logic
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_armed;
    seq_wait && seq_cmd.trig && !seq_cmd.abort && !st_ff.init_on && !init_start;
  endsequence

  sequence s_measuring;
    seq_meas && !seq_wait;
  endsequence

  property p_trig_to_meas;
    s_armed |=> s_measuring;
  endproperty
  a_trig_to_meas: assert property (p_trig_to_meas)
    else $error("trigger did not move waiting to measuring");

  property p_cal_level;
    !st_ff.cal_on && cal_start && !init_start && !st_ff.init_on |=> st_ff.cal_on;
  endproperty
  a_cal_level: assert property (p_cal_level)
    else $error("calibration start not shown in condition");

  property p_cal_evt;
    $changed(cond_vec[osh_pkg::SUB_CAL]) |=> evt_vec[osh_pkg::SUB_CAL];
  endproperty
  a_cal_evt: assert property (p_cal_evt)
    else $error("calibration change not latched");

  property p_meas_evt;
    $changed(seq_meas) |=> evt_vec[osh_pkg::SUB_MEAS];
  endproperty
  a_meas_evt: assert property (p_meas_evt)
    else $error("measurement change not latched");

  property p_meas_excl;
    !(seq_meas && seq_wait);
  endproperty
  a_meas_excl: assert property (p_meas_excl)
    else $error("measuring and waiting both set");

  property p_wait_evt;
    seq_wait |=> evt_vec[osh_pkg::SUB_TRIG];
  endproperty
  a_wait_evt: assert property (p_wait_evt)
    else $error("trigger wait not latched");

  property p_arm_wait;
    $past(seq_cmd.arm) && $past(!seq_wait && !seq_meas) && $past(!init_start)
      && $past(!st_ff.init_on) && $past(!seq_cmd.abort) |-> seq_wait;
  endproperty
  a_arm_wait: assert property (p_arm_wait)
    else $error("arming did not enter trigger wait");

  property p_init_cause;
    init_start |=> st_ff.init_on [*2];
  endproperty
  a_init_cause: assert property (p_init_cause)
    else $error("init cause did not start initialization");

  property p_init_len;
    $rose(st_ff.init_on) |-> st_ff.init_on ##[1:1000] !st_ff.init_on;
  endproperty
  a_init_len: assert property (p_init_len)
    else $error("initialization did not end in time");

  property p_init_evt;
    $changed(st_ff.init_on) |=> evt_vec[osh_pkg::SUB_INIT];
  endproperty
  a_init_evt: assert property (p_init_evt)
    else $error("init change not latched");

  property p_low;
    smp_valid && !init_start && !st_ff.init_on |=>
      st_ff.low_on == $past(smp_value < low_limit)
      ##1 (evt_vec[osh_pkg::SUB_LOW] || !$past(st_ff.low_on));
  endproperty
  a_low: assert property (p_low)
    else $error("low bound condition wrong");

  property p_low_evt;
    st_ff.low_on |=> evt_vec[osh_pkg::SUB_LOW];
  endproperty
  a_low_evt: assert property (p_low_evt)
    else $error("low bound event not latched");

  property p_high;
    smp_valid && !init_start && !st_ff.init_on |=> st_ff.high_on == $past(smp_value > high_limit);
  endproperty
  a_high: assert property (p_high)
    else $error("high bound condition wrong");

  property p_high_evt;
    st_ff.high_on |=> evt_vec[osh_pkg::SUB_HIGH];
  endproperty
  a_high_evt: assert property (p_high_evt)
    else $error("high bound event not latched");

  property p_sub_shape;
    qry.valid && qry.sel != osh_pkg::SEL_OP_COND && qry.sel != osh_pkg::SEL_OP_EVT
      |=> ans.ack && ans.data[0] == 1'b0 && ans.data[osh_pkg::REG_W-1:2] == '0;
  endproperty
  a_sub_shape: assert property (p_sub_shape)
    else $error("unused sub-register bits not zero");

  property p_evt_clear;
    qry.valid && qry.sel == osh_pkg::SEL_CAL_EVT && !$changed(cond_vec[osh_pkg::SUB_CAL])
      && !$changed(cond_vec[osh_pkg::SUB_CAL]) ##1 !$changed(cond_vec[osh_pkg::SUB_CAL])
      |-> !evt_vec[osh_pkg::SUB_CAL];
  endproperty
  a_evt_clear: assert property (p_evt_clear)
    else $error("event read did not clear");

  property p_op_low;
    qry.valid && qry.sel == osh_pkg::SEL_OP_EVT |=>
      ans.data[osh_pkg::SUM_CAL] == $past(evt_vec[osh_pkg::SUB_CAL])
      && ans.data[osh_pkg::SUM_MEAS] == $past(evt_vec[osh_pkg::SUB_MEAS])
      && ans.data[osh_pkg::SUM_TRIG] == $past(evt_vec[osh_pkg::SUB_TRIG]);
  endproperty
  a_op_low: assert property (p_op_low)
    else $error("low summary bits misplaced");

  property p_op_high;
    qry.valid && qry.sel == osh_pkg::SEL_OP_EVT |=>
      ans.data[osh_pkg::SUM_INIT] == $past(evt_vec[osh_pkg::SUB_INIT])
      && ans.data[osh_pkg::SUM_LOW] == $past(evt_vec[osh_pkg::SUB_LOW])
      && ans.data[osh_pkg::SUM_HIGH] == $past(evt_vec[osh_pkg::SUB_HIGH]);
  endproperty
  a_op_high: assert property (p_op_high)
    else $error("high summary bits misplaced");

  property p_op_sum;
    qry.valid && qry.sel == osh_pkg::SEL_OP_EVT |=> (|ans.data) == $past(|evt_vec);
  endproperty
  a_op_sum: assert property (p_op_sum)
    else $error("summary not OR of event bits");

  property p_op_cond;
    qry.valid && qry.sel == osh_pkg::SEL_OP_COND |=>
      ans.data[osh_pkg::SUM_MEAS] == $past(seq_meas)
      && ans.data[osh_pkg::SUM_TRIG] == $past(seq_wait);
  endproperty
  a_op_cond: assert property (p_op_cond)
    else $error("operation condition wrong");

endmodule // osh_core

// >>> verif/osh_host.sv
`timescale 1ns/1ns
// remote host: one status query per call, answer taken in the ack cycle
module osh_host (
  input  wire logic                 clk,  // instrument clock
  output osh_pkg::osh_query_t       qry,  // query to the block
  input  wire osh_pkg::osh_answer_t ans   // answer from the block
);
  // idle state before the first query
  initial
  begin
    qry.valid = 1'b0;
    qry.sel   = osh_pkg::SEL_OP_COND;
  end

  // request set at the falling edge, held over the taking rising edge;
  // the selector is inverted when idle so a block reading it without valid is caught
  task automatic ask(
    input  logic [3:0]  s,  // selector code
    output logic [15:0] d,  // answer word
    output logic        ok  // ack seen half a cycle after taking
  );
    @(negedge clk);
    qry.valid = 1'b1;
    qry.sel   = osh_pkg::osh_sel_t'(s);
    @(negedge clk);
    qry.valid = 1'b0;
    qry.sel   = osh_pkg::osh_sel_t'(~s);
    ok        = ans.ack;
    d         = ans.data;
  endtask
endmodule // osh_host

// >>> verif/test_operation_status_hierarchy.sv
`timescale 1ns/1ns
module test_operation_status_hierarchy;
  // short init keeps the run brief; the power-up busy count is checked against this value
  localparam int          INIT_N = 8;
  localparam int          VW     = 24;
  localparam logic [15:0] F      = 16'h0001 << osh_pkg::FLAG_BIT;

  logic                  clk;
  logic                  nrst;
  logic [9:0]            pk;          // pulse inputs, one bit each
  logic signed [VW-1:0]  smp_value;
  logic signed [VW-1:0]  low_limit;
  logic signed [VW-1:0]  high_limit;
  logic                  init_busy;
  osh_pkg::osh_query_t   qry;
  osh_pkg::osh_answer_t  ans;
  osh_pkg::osh_seq_cmd_t seq_cmd;
  int                    failures;
  int                    checks;

  // sequencer pulses: arm 8, trig 7, done 6, abort 5
  assign seq_cmd = pk[8:5];

  osh_core #(
    .VAL_W       (VW),
    .INIT_CYCLES (INIT_N)
  ) osh_core_i (
    .clk(clk), .nrst(nrst), .qry(qry), .ans(ans), .connect_evt(pk[0]),
    .cmd_reset(pk[1]), .cmd_preset(pk[2]), .cal_start(pk[3]), .cal_done(pk[4]),
    .seq_cmd(seq_cmd), .smp_valid(pk[9]), .smp_value(smp_value),
    .low_limit(low_limit), .high_limit(high_limit), .init_busy(init_busy)
  );

  osh_host osh_host_i (.clk(clk), .qry(qry), .ans(ans));

  // 25 MHz clock
  always #20 clk = ~clk;

  function automatic logic [15:0] bw(input int p);
    return 16'h0001 << p;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one query; the ack must stand half a cycle after the taking edge
  task automatic rd(input logic [3:0] s, input logic [15:0] e);
    logic [15:0] d;
    logic        ok;
    osh_host_i.ask(s, d, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(d, e);
  endtask

  task automatic pulse(input int b);
    @(negedge clk);
    pk[b] = 1'b1;
    @(negedge clk);
    pk[b] = 1'b0;
  endtask

  task automatic smp(input int v);
    @(negedge clk);
    smp_value = VW'(v);
    pk[9]     = 1'b1;
    @(negedge clk);
    pk[9]     = 1'b0;
  endtask

  // bounded wait for the end of an initialization, returns cycles seen busy
  task automatic wait_init(output int n);
    n = 0;
    while (init_busy === 1'b1 && n < 40)
    begin
      n++;
      @(negedge clk);
    end
    if (n >= 40)
    begin
      failures++;
      end_sim();
    end
  endtask

  initial
  begin
    int n;
    clk        = 1'b0;
    nrst       = 1'b0;
    pk         = '0;
    smp_value  = '0;
    low_limit  = -24'sd100;
    high_limit = 24'sd100;
    failures   = 0;
    checks     = 0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;

    // power-up initialization and its events
    wait_init(n);
    chk(16'(n), 16'(INIT_N));
    rd(osh_pkg::SEL_INIT_COND, 16'h0000);
    rd(osh_pkg::SEL_OP_EVT, bw(osh_pkg::SUM_INIT));
    rd(osh_pkg::SEL_INIT_EVT, F);
    rd(osh_pkg::SEL_INIT_EVT, 16'h0000);
    rd(osh_pkg::SEL_OP_EVT, 16'h0000);
    rd(4'hE, 16'h0000);
    rd(4'hF, 16'h0000);
    $display("test power_up done");

    // connect, reset command and preset command each start an init
    for (int i = 0; i < 3; i++)
    begin
      pulse(i);
      rd(osh_pkg::SEL_INIT_COND, F);
      rd(osh_pkg::SEL_OP_COND, bw(osh_pkg::SUM_INIT));
      wait_init(n);
      rd(osh_pkg::SEL_INIT_EVT, F);
      rd(osh_pkg::SEL_INIT_EVT, 16'h0000);
    end
    $display("test init_causes done");

    // calibration start and end both latch
    pulse(3);
    rd(osh_pkg::SEL_CAL_COND, F);
    rd(osh_pkg::SEL_OP_COND, bw(osh_pkg::SUM_CAL));
    rd(osh_pkg::SEL_OP_EVT, bw(osh_pkg::SUM_CAL));
    rd(osh_pkg::SEL_CAL_EVT, F);
    rd(osh_pkg::SEL_OP_EVT, 16'h0000);
    pulse(4);
    rd(osh_pkg::SEL_CAL_COND, 16'h0000);
    rd(osh_pkg::SEL_CAL_EVT, F);
    rd(osh_pkg::SEL_CAL_EVT, 16'h0000);
    $display("test calibration done");

    // arm, trigger, measure, done; then arm and abort
    pulse(8);
    rd(osh_pkg::SEL_TRIG_COND, F);
    rd(osh_pkg::SEL_OP_COND, bw(osh_pkg::SUM_TRIG));
    pulse(7);
    rd(osh_pkg::SEL_TRIG_COND, 16'h0000);
    rd(osh_pkg::SEL_MEAS_COND, F);
    rd(osh_pkg::SEL_OP_COND, bw(osh_pkg::SUM_MEAS));
    rd(osh_pkg::SEL_TRIG_EVT, F);
    rd(osh_pkg::SEL_TRIG_EVT, 16'h0000);
    rd(osh_pkg::SEL_MEAS_EVT, F);
    pulse(6);
    rd(osh_pkg::SEL_MEAS_COND, 16'h0000);
    rd(osh_pkg::SEL_MEAS_EVT, F);
    rd(osh_pkg::SEL_MEAS_EVT, 16'h0000);
    pulse(8);
    pulse(5);
    rd(osh_pkg::SEL_TRIG_COND, 16'h0000);
    rd(osh_pkg::SEL_MEAS_COND, 16'h0000);
    rd(osh_pkg::SEL_TRIG_EVT, F);
    $display("test trigger_measure done");

    // limits, including values equal to each limit
    smp(-101);
    rd(osh_pkg::SEL_LOW_COND, F);
    rd(osh_pkg::SEL_HIGH_COND, 16'h0000);
    smp(-100);
    rd(osh_pkg::SEL_LOW_COND, 16'h0000);
    rd(osh_pkg::SEL_OP_EVT, bw(osh_pkg::SUM_LOW));
    rd(osh_pkg::SEL_LOW_EVT, F);
    rd(osh_pkg::SEL_LOW_EVT, 16'h0000);
    smp(101);
    rd(osh_pkg::SEL_HIGH_COND, F);
    rd(osh_pkg::SEL_OP_COND, bw(osh_pkg::SUM_HIGH));
    smp(100);
    rd(osh_pkg::SEL_HIGH_COND, 16'h0000);
    rd(osh_pkg::SEL_HIGH_EVT, F);
    rd(osh_pkg::SEL_HIGH_EVT, 16'h0000);
    rd(osh_pkg::SEL_OP_EVT, 16'h0000);
    $display("test limits done");
    end_sim();
  end
endmodule // test_operation_status_hierarchy
